//--- shared/fus_map.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  serial port status block. Assumes a 4-bit byte address on the register port.
*/
`ifndef FUS_MAP_SVH
`define FUS_MAP_SVH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define FUS_OFS_STATUS   4'h0
`define FUS_OFS_CTRL     4'h4
`define FUS_OFS_TXPORT   4'h8
`define FUS_OFS_RXPORT   4'hC

// ------------------------------------------------------------------
// Status word fields
// ------------------------------------------------------------------
`define FUS_ST_HEAD_FRAME 3
`define FUS_ST_TX_DONE    6
`define FUS_ST_TX_LOW     5
`define FUS_ST_LONG_SPACE 4
`define FUS_ST_RX_FULL    1
`define FUS_ST_RX_IDLE    0
`define FUS_ST_RX_FAULT   7
`define FUS_ST_RESET     16'h0060
`define FUS_FLAGS_RESET  8'h60
`define FUS_CLR_MASK     8'hF3

// ------------------------------------------------------------------
// Control word fields
// ------------------------------------------------------------------
`define FUS_CT_RX_ON     0
`define FUS_CT_TX_ON     1
`define FUS_CT_PAR_EN    2
`define FUS_CT_PAR_ODD   3
`define FUS_CT_TWO_STOP  4
`define FUS_CT_TTRG_LO   5
`define FUS_CT_RTRG_LO   7
`define FUS_CT_WIDTH     9

// ------------------------------------------------------------------
// FIFO sizes, trigger levels and idle time
// ------------------------------------------------------------------
`define FUS_DEPTH        16
`define FUS_PTR_W        4
`define FUS_CNT_W        5
`define FUS_TX_TRIG0     5'h08
`define FUS_TX_TRIG1     5'h04
`define FUS_TX_TRIG2     5'h02
`define FUS_TX_TRIG3     5'h01
`define FUS_RX_TRIG0     5'h01
`define FUS_RX_TRIG1     5'h04
`define FUS_RX_TRIG2     5'h08
`define FUS_RX_TRIG3     5'h0E
`define FUS_IDLE_ETU     4'hF

`endif

//--- shared/fus_pkg.sv
/*
  Types of the serial port status block: the single state record.
  Assumes fus_map.svh is reachable on the include path.
*/
`include "fus_map.svh"

package fus_pkg;

  typedef struct packed {
    logic [`FUS_CT_WIDTH-1:0]          ctl;
    logic [7:0]                        flags;
    logic [7:0]                        armed;
    logic [`FUS_DEPTH-1:0][9:0]        rxq;
    logic [`FUS_PTR_W-1:0]             rx_rp;
    logic [`FUS_PTR_W-1:0]             rx_wp;
    logic [`FUS_CNT_W-1:0]             rx_cnt;
    logic [`FUS_DEPTH-1:0][7:0]        txq;
    logic [`FUS_PTR_W-1:0]             tx_rp;
    logic [`FUS_PTR_W-1:0]             tx_wp;
    logic [`FUS_CNT_W-1:0]             tx_cnt;
    logic [`FUS_CNT_W-1:0]             low_wrs;
    logic                              space_hold;
    logic [3:0]                        idle_cnt;
    logic                              line_s1;
    logic                              line_s2;
    logic [15:0]                       rdata;
  } fus_state_s;

endpackage

//--- design/fus_status.sv
/*
  Status flag logic of a FIFO-buffered asynchronous serial port, with its
  receive and transmit FIFOs, control word and register port.
  Assumes a receive shifter and a transmit shifter on core_clk that deliver
  and take characters by the ports below, and a baud divider giving etu_tick.
*/

`timescale 1ns/10ps
`include "fus_map.svh"

module fus_status
  import fus_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        standby,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        etu_tick,
  input  wire logic        rx_line_pin,
  input  wire logic        rx_char_valid,
  input  wire logic [7:0]  rx_char_data,
  input  wire logic        rx_char_par,
  input  wire logic        rx_char_stop,
  input  wire logic        tx_load_ready,
  output logic             tx_load_valid,
  output logic      [7:0]  tx_load_data,
  input  wire logic        tx_last_bit,
  output logic             rx_on,
  output logic             tx_on,
  output logic             par_en,
  output logic             par_odd,
  output logic             two_stop,
  output logic      [15:0] uart_status_word
);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [`FUS_CNT_W-1:0] trig_val(input logic [1:0] sel,
                                                     input logic       is_tx);
    logic [`FUS_CNT_W-1:0] v;
    v = '0;
    case (sel)
      2'h0:    v = is_tx ? `FUS_TX_TRIG0 : `FUS_RX_TRIG0;
      2'h1:    v = is_tx ? `FUS_TX_TRIG1 : `FUS_RX_TRIG1;
      2'h2:    v = is_tx ? `FUS_TX_TRIG2 : `FUS_RX_TRIG2;
      default: v = is_tx ? `FUS_TX_TRIG3 : `FUS_RX_TRIG3;
    endcase
    return v;
  endfunction

  // Counts a fault bit over the occupied entries; saturates at 15
  function automatic logic [3:0] fault_cnt(input logic [`FUS_DEPTH-1:0][9:0] q,
                                           input logic [`FUS_PTR_W-1:0]      rp,
                                           input logic [`FUS_CNT_W-1:0]      cnt,
                                           input int                         b);
    logic [4:0]            n;
    logic [`FUS_PTR_W-1:0] idx;
    n   = '0;
    idx = rp;
    for (int i = 0; i < `FUS_DEPTH; i++) begin
      if ((5'(i) < cnt) && q[idx][b]) begin
        n = n + 5'h01;
      end
      idx = idx + 4'h1;
    end
    return (n > 5'h0F) ? 4'hF : n[3:0];
  endfunction

  function automatic fus_state_s init_state();
    fus_state_s s;
    s          = '0;
    s.flags    = `FUS_FLAGS_RESET;
    s.idle_cnt = `FUS_IDLE_ETU;
    s.line_s1  = 1'b1;
    s.line_s2  = 1'b1;
    return s;
  endfunction

  // Standby reuses the reset image, so both paths agree bit for bit
  localparam fus_state_s ST_RST = init_state();
  // Bits 3 and 2 mirror the head character and never clear by write
  localparam logic [7:0] CLR_MASK = `FUS_CLR_MASK;

  fus_state_s            cur;
  fus_state_s            next_st;
  logic [9:0]            rx_head;
  logic                  head_frame;
  logic                  head_par;
  logic [`FUS_CNT_W-1:0] tx_trig;
  logic [`FUS_CNT_W-1:0] rx_trig;
  logic [15:0]           st_word;

  // ------------------------------------------------------------------
  // Status word assembly
  // ------------------------------------------------------------------
  assign rx_head  = cur.rxq[cur.rx_rp];
  // head fault bits
  // Head bits read 0 when the FIFO is empty
  assign head_frame = (cur.rx_cnt != '0) && rx_head[8];
  assign head_par   = (cur.rx_cnt != '0) && rx_head[9];
  assign tx_trig  = trig_val(cur.ctl[`FUS_CT_TTRG_LO +: 2], 1'b1);
  assign rx_trig  = trig_val(cur.ctl[`FUS_CT_RTRG_LO +: 2], 1'b0);
  assign st_word  = {fault_cnt(cur.rxq, cur.rx_rp, cur.rx_cnt, 9),
                     fault_cnt(cur.rxq, cur.rx_rp, cur.rx_cnt, 8),
                     cur.flags[7:4], head_frame, head_par, cur.flags[1:0]};

  assign uart_status_word = st_word;
  assign reg_rdata        = cur.rdata;
  assign rx_on            = cur.ctl[`FUS_CT_RX_ON];
  assign tx_on            = cur.ctl[`FUS_CT_TX_ON];
  assign par_en           = cur.ctl[`FUS_CT_PAR_EN];
  assign par_odd          = cur.ctl[`FUS_CT_PAR_ODD];
  assign two_stop         = cur.ctl[`FUS_CT_TWO_STOP];
  // Gated by tx_on so a disabled transmitter never drains the FIFO
  assign tx_load_valid    = tx_on && (cur.tx_cnt != '0);
  assign tx_load_data     = cur.txq[cur.tx_rp];

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    logic [7:0]            set_ev;
    logic                  tx_push;
    logic                  tx_pop;
    logic                  rx_pop;
    logic                  rx_push;
    logic                  frame_bad;
    logic                  par_bad;
    logic [`FUS_CNT_W-1:0] tx_new;
    logic [`FUS_CNT_W-1:0] rx_new;
    set_ev  = '0;
    tx_push = 1'b0;
    tx_pop  = 1'b0;
    rx_pop  = 1'b0;
    rx_push = 1'b0;
    frame_bad = 1'b0;
    par_bad   = 1'b0;
    tx_new  = '0;
    rx_new  = '0;
    next_st = cur;
    // Read data stands for one cycle only
    next_st.rdata   = '0;
    // Pin level crosses in through two flops
    next_st.line_s1 = rx_line_pin;
    next_st.line_s2 = cur.line_s1;

    // Register reads
    if (reg_rd) begin
      case (reg_addr)
        `FUS_OFS_STATUS: begin
          next_st.rdata = st_word;
          next_st.armed = cur.armed | (st_word[7:0] & `FUS_CLR_MASK);
        end
        `FUS_OFS_CTRL: begin
          next_st.rdata = {{(16-`FUS_CT_WIDTH){1'b0}}, cur.ctl};
        end
        `FUS_OFS_TXPORT: begin
          next_st.rdata = {3'h0, cur.tx_cnt, 8'h00};
        end
        `FUS_OFS_RXPORT: begin
          // Empty reads return 0 and leave the pointers alone
          if (cur.rx_cnt != '0) begin
            next_st.rdata = {8'h00, rx_head[7:0]};
            rx_pop        = 1'b1;
          end
        end
        default: begin
          next_st.rdata = '0;
        end
      endcase
    end

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        `FUS_OFS_STATUS: begin
          for (int i = 0; i < 8; i++) begin
            // masked bits 3 and 2; zero after read
            if (CLR_MASK[i] && !reg_wdata[i] && cur.armed[i]) begin
              // Full flag holds while the count still exceeds the trigger
              if ((i != `FUS_ST_RX_FULL) || !(cur.rx_cnt > rx_trig)) begin
                next_st.flags[i] = 1'b0;
              end
              next_st.armed[i] = 1'b0;
            end
          end
        end
        `FUS_OFS_CTRL: begin
          next_st.ctl = reg_wdata[`FUS_CT_WIDTH-1:0];
        end
        `FUS_OFS_TXPORT: begin
          if ((cur.tx_cnt != 5'(`FUS_DEPTH)) &&
              !(cur.flags[`FUS_ST_TX_LOW] &&
                (cur.low_wrs >= 5'(`FUS_DEPTH) - tx_trig))) begin
            next_st.txq[cur.tx_wp] = reg_wdata[7:0];
            next_st.tx_wp          = cur.tx_wp + 4'h1;
            next_st.low_wrs        = cur.low_wrs + 5'h01;
            tx_push                = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // ------------------------------------------------------------------
    // Transmit side
    // ------------------------------------------------------------------
    if (tx_load_valid && tx_load_ready) begin
      next_st.tx_rp = cur.tx_rp + 4'h1;
      tx_pop        = 1'b1;
    end
    tx_new = cur.tx_cnt + 5'(tx_push) - 5'(tx_pop);
    next_st.tx_cnt = tx_new;
    if (tx_push) begin
      next_st.flags[`FUS_ST_TX_DONE] = 1'b0;
    end
    if (tx_push && (tx_new > tx_trig)) begin
      next_st.flags[`FUS_ST_TX_LOW] = 1'b0;
    end
    if (tx_pop && (tx_new < tx_trig)) begin
      set_ev[`FUS_ST_TX_LOW] = 1'b1;
      // Write budget restarts each time the low flag sets
      next_st.low_wrs        = '0;
    end
    if (tx_last_bit && (tx_new == '0)) begin
      set_ev[`FUS_ST_TX_DONE] = 1'b1;
    end
    if (!tx_on) begin
      set_ev[`FUS_ST_TX_DONE] = 1'b1;
    end

    // ------------------------------------------------------------------
    // Receive side
    // ------------------------------------------------------------------
    // mark level ends the hold
    if (cur.space_hold && cur.line_s2) begin
      next_st.space_hold = 1'b0;
    end
    if (rx_char_valid && rx_on) begin
      frame_bad = !rx_char_stop;
      par_bad = par_en && ((^{rx_char_data, rx_char_par}) != par_odd);
      if (frame_bad || par_bad) begin
        set_ev[`FUS_ST_RX_FAULT] = 1'b1;
      end
      if (!cur.space_hold && (cur.rx_cnt != 5'(`FUS_DEPTH))) begin
        next_st.rxq[cur.rx_wp] = {par_bad, frame_bad, rx_char_data};
        next_st.rx_wp          = cur.rx_wp + 4'h1;
        rx_push                = 1'b1;
      end
      if (frame_bad && !cur.line_s2) begin
        set_ev[`FUS_ST_LONG_SPACE] = 1'b1;
        next_st.space_hold         = 1'b1;
      end
      next_st.idle_cnt = '0;
    end
    if (rx_pop) begin
      next_st.rx_rp = cur.rx_rp + 4'h1;
    end
    rx_new = cur.rx_cnt + 5'(rx_push) - 5'(rx_pop);
    next_st.rx_cnt = rx_new;
    if (rx_new > rx_trig) begin
      set_ev[`FUS_ST_RX_FULL] = 1'b1;
    end
    // idle bit-time count
    // Counter parks at 15 so one quiet gap flags idle only once
    if (etu_tick && !(rx_char_valid && rx_on) && (cur.idle_cnt != `FUS_IDLE_ETU)) begin
      next_st.idle_cnt = cur.idle_cnt + 4'h1;
      if ((cur.idle_cnt == `FUS_IDLE_ETU - 4'h1) && (rx_new != '0) && (rx_new < rx_trig)) begin
        set_ev[`FUS_ST_RX_IDLE] = 1'b1;
      end
    end

    // Hardware sets win over clears
    for (int i = 0; i < 8; i++) begin
      if (set_ev[i]) begin
        next_st.flags[i] = 1'b1;
        // new set needs a new read
        next_st.armed[i] = 1'b0;
      end
    end

    if (standby) begin
      next_st = ST_RST;
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cur <= ST_RST;
    end else begin
      cur <= next_st;
    end
  end

endmodule

//--- dv/fus_checker.sv
/*
  Port checker of the serial port status block.
  Assumes it is bound to fus_status and sees only that module's ports.
*/
`timescale 1ns/10ps

module fus_checker (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        standby,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        rx_char_valid,
  input wire logic [7:0]  rx_char_data,
  input wire logic        rx_char_par,
  input wire logic        rx_char_stop,
  input wire logic        tx_last_bit,
  input wire logic        rx_on,
  input wire logic        tx_on,
  input wire logic        par_en,
  input wire logic        par_odd,
  input wire logic [15:0] uart_status_word
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // --------------------------------------------------------------
  // Clearing handshake, reset, read data and flag checks
  // --------------------------------------------------------------
  // Gap cycle matches the bench: a read, one idle cycle, then the write
  sequence s_rd_fault;
    reg_rd && reg_addr == 4'h0 && uart_status_word[7] && !rx_char_valid;
  endsequence
  sequence s_wr_fault0;
    reg_wr && reg_addr == 4'h0 && !reg_wdata[7] && !rx_char_valid;
  endsequence
  AST_CLR: assert property (s_rd_fault ##1 !rx_char_valid ##1 s_wr_fault0
    |=> !uart_status_word[7])
    else $error("fault flag not cleared");
  AST_NOSET: assert property (reg_wr && reg_addr == 4'h0 && !rx_char_valid && !standby
    && !uart_status_word[7] |=> !uart_status_word[7])
    else $error("write set fault flag");
  AST_FERRO: assert property (reg_wr && reg_addr == 4'h0 && !rx_char_valid && !standby
    |=> $stable(uart_status_word[3:2]))
    else $error("read-only bits changed");
  AST_RST: assert property (!$past(rstn) |-> uart_status_word == 16'h0060)
    else $error("status not at reset value");
  AST_STBY: assert property (standby |=> uart_status_word == 16'h0060)
    else $error("standby value wrong");
  AST_RD0: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside answer cycle");
  AST_RDST: assert property (reg_rd && reg_addr == 4'h0
    |=> reg_rdata == $past(uart_status_word))
    else $error("status read mismatch");
  AST_ERSTOP: assert property (rx_char_valid && rx_on && !rx_char_stop
    |=> uart_status_word[7])
    else $error("stop fault missed");
  AST_ERPAR: assert property (rx_char_valid && rx_on && par_en
    && ((^rx_char_data ^ rx_char_par) != par_odd) |=> uart_status_word[7])
    else $error("parity fault missed");
  AST_RXOFF: assert property (!rx_on && !(reg_wr && reg_addr == 4'h0) && !standby
    |=> $stable(uart_status_word[7]))
    else $error("fault flag moved while off");
  AST_TENDOFF: assert property (!tx_on |=> uart_status_word[6])
    else $error("done flag low while off");
  AST_TENDCLR: assert property (reg_wr && reg_addr == 4'h8 && tx_on && !standby
    && !uart_status_word[5] && !tx_last_bit |=> !uart_status_word[6])
    else $error("done flag kept after write");
endmodule

bind fus_status fus_checker u_chk (.core_clk, .rstn, .standby, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .rx_char_valid, .rx_char_data, .rx_char_par, .rx_char_stop,
  .tx_last_bit, .rx_on, .tx_on, .par_en, .par_odd, .uart_status_word);

//--- dv/fus_far_model.sv
/*
  Far side of the serial line: receive shifter, transmit shifter, bit ticks.
  Assumes the bench calls its tasks and sets ready_en to release the shifter.
*/
`timescale 1ns/10ps

module fus_far_model (
  input  wire logic       core_clk,
  input  wire logic       tx_load_valid,
  input  wire logic [7:0] tx_load_data,
  output logic            tx_load_ready,
  output logic            tx_last_bit,
  output logic            etu_tick,
  output logic            rx_line_pin,
  output logic            rx_char_valid,
  output logic [7:0]      rx_char_data,
  output logic            rx_char_par,
  output logic            rx_char_stop
);
  logic       ready_en = 1'b0;
  logic [2:0] busy = 3'h0;
  logic [7:0] got[$];
  initial begin
    tx_last_bit = 1'b0;
    etu_tick = 1'b0;
    rx_line_pin = 1'b1;
    rx_char_valid = 1'b0;
  end
  assign tx_load_ready = ready_en && busy == 3'h0;
  always @(posedge core_clk) begin
    tx_last_bit <= busy == 3'h1;
    if (tx_load_valid && tx_load_ready) begin
      got.push_back(tx_load_data);
      busy <= 3'h4;
    end else if (busy != 3'h0) begin
      busy <= busy - 3'h1;
    end
  end
  task automatic send(input logic [7:0] d, input logic p, input logic s);
    @(posedge core_clk);
    rx_char_valid <= 1'b1;
    rx_char_data  <= d;
    rx_char_par   <= p;
    rx_char_stop  <= s;
    @(posedge core_clk);
    // Released lines never keep the last value
    rx_char_valid <= 1'b0;
    rx_char_data  <= ~d;
    rx_char_par   <= ~p;
    rx_char_stop  <= ~s;
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge core_clk);
      etu_tick <= 1'b1;
      @(posedge core_clk);
      etu_tick <= 1'b0;
    end
  endtask
endmodule

//--- dv/fus_status_tb.sv
/*
  Bench of the status block: register tasks and one task a scenario.
  Assumes fus_far_model on the serial side and fus_checker bound in.
*/
`timescale 1ns/10ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end

module fus_status_tb;
  logic        core_clk, rstn, standby, reg_wr, reg_rd, etu_tick, rx_line_pin;
  logic        rx_char_valid, rx_char_par, rx_char_stop, tx_load_ready, tx_load_valid;
  logic        tx_last_bit, rx_on, tx_on, par_en, par_odd, two_stop;
  logic [3:0]  reg_addr;
  logic [7:0]  rx_char_data, tx_load_data;
  logic [15:0] reg_wdata, reg_rdata, uart_status_word, v;
  int          num_errors, n_compared, cyc;
  fus_status u_dut (.core_clk, .rstn, .standby, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .etu_tick, .rx_line_pin, .rx_char_valid, .rx_char_data, .rx_char_par,
    .rx_char_stop, .tx_load_ready, .tx_load_valid, .tx_load_data, .tx_last_bit, .rx_on,
    .tx_on, .par_en, .par_odd, .two_stop, .uart_status_word);
  fus_far_model u_far (.core_clk, .tx_load_valid, .tx_load_data, .tx_load_ready,
    .tx_last_bit, .etu_tick, .rx_line_pin, .rx_char_valid, .rx_char_data, .rx_char_par,
    .rx_char_stop);
  always #10 core_clk = ~core_clk;
  // Whole run is a few hundred cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] q);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    q = reg_rdata;
  endtask
  task automatic pulse_standby;
    @(posedge core_clk);
    standby <= 1'b1;
    @(posedge core_clk);
    standby <= 1'b0;
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_fault;
    rd(4'h0, v);
    `CHK(v, 16'h0060)
    rd(4'h2, v);
    `CHK(v, 16'h0000)
    wr(4'h4, 16'h0001);
    u_far.send(8'hA5, 1'b0, 1'b0);
    u_far.send(8'h3C, 1'b0, 1'b1);
    wr(4'h0, 16'h0000);
    rd(4'h0, v);
    `CHK(v, 16'h01CA)
    wr(4'h0, 16'h0000);
    rd(4'h0, v);
    `CHK(v, 16'h014A)
    wr(4'h0, 16'h00F3);
    rd(4'h0, v);
    `CHK(v[3:2], 2'b10)
    rd(4'hC, v);
    `CHK(v[7:0], 8'hA5)
    rd(4'h0, v);
    `CHK(v[11:8], 4'h0)
    `CHK(v[3], 1'b0)
    rd(4'hC, v);
    `CHK(v[7:0], 8'h3C)
    $display("test fault done");
  endtask
  task automatic t_parity;
    wr(4'h4, 16'h0015);
    rd(4'h4, v);
    `CHK(v, 16'h0015)
    `CHK(two_stop, 1'b1)
    u_far.send(8'h01, 1'b0, 1'b1);
    u_far.send(8'h03, 1'b0, 1'b1);
    rd(4'h0, v);
    `CHK(v[15:12], 4'h1)
    `CHK(v[7], 1'b1)
    `CHK(v[3:2], 2'b01)
    wr(4'h4, 16'h0014);
    rd(4'h0, v);
    `CHK(v[7], 1'b1)
    rd(4'hC, v);
    `CHK(v[7:0], 8'h01)
    rd(4'hC, v);
    wr(4'h4, 16'h001D);
    u_far.send(8'h01, 1'b0, 1'b1);
    rd(4'h0, v);
    `CHK(v[15:12], 4'h0)
    rd(4'hC, v);
    `CHK(v[7:0], 8'h01)
    u_far.send(8'h02, 1'b1, 1'b1);
    wr(4'h0, 16'h0000);
    rd(4'h0, v);
    `CHK(v[7], 1'b1)
    rd(4'hC, v);
    $display("test parity done");
  endtask
  task automatic t_full_idle;
    wr(4'h4, 16'h0081);
    rd(4'h0, v);
    wr(4'h0, 16'h0000);
    for (int i = 0; i < 4; i++) u_far.send(8'(i), 1'b0, 1'b1);
    rd(4'h0, v);
    `CHK(v[1], 1'b0)
    u_far.send(8'h44, 1'b0, 1'b1);
    rd(4'h0, v);
    `CHK(v[1], 1'b1)
    repeat (5) rd(4'hC, v);
    u_far.send(8'h55, 1'b0, 1'b1);
    u_far.tick(14);
    rd(4'h0, v);
    `CHK(v[0], 1'b0)
    u_far.tick(1);
    rd(4'h0, v);
    `CHK(v[0], 1'b1)
    rd(4'hC, v);
    $display("test full idle done");
  endtask
  task automatic t_break;
    u_far.rx_line_pin <= 1'b0;
    repeat (3) @(posedge core_clk);
    u_far.send(8'h00, 1'b0, 1'b0);
    u_far.send(8'h5A, 1'b0, 1'b1);
    rd(4'h0, v);
    `CHK(v[4], 1'b1)
    rd(4'hC, v);
    `CHK(v, 16'h0000)
    rd(4'hC, v);
    `CHK(v, 16'h0000)
    u_far.rx_line_pin <= 1'b1;
    repeat (3) @(posedge core_clk);
    u_far.send(8'h33, 1'b0, 1'b1);
    rd(4'hC, v);
    `CHK(v[7:0], 8'h33)
    $display("test break done");
  endtask
  task automatic t_tx;
    pulse_standby();
    rd(4'h0, v);
    `CHK(v, 16'h0060)
    for (int i = 0; i < 10; i++) wr(4'h8, 16'(i));
    rd(4'h8, v);
    `CHK(v[12:8], 5'h08)
    pulse_standby();
    wr(4'h4, 16'h0060);
    wr(4'h8, 16'h00C1);
    wr(4'h8, 16'h00C2);
    wr(4'h4, 16'h0062);
    wr(4'h8, 16'h00C3);
    rd(4'h0, v);
    `CHK(v[6:5], 2'b00)
    @(posedge core_clk);
    u_far.ready_en <= 1'b1;
    for (int i = 0; i < 100 && uart_status_word[6] !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    `CHK(uart_status_word[6:5], 2'b11)
    for (int i = 0; i < 3; i++) `CHK(u_far.got[i], 8'hC1 + 8'(i))
    wr(4'h4, 16'h0060);
    $display("test tx done");
  endtask
  initial begin
    core_clk = 1'b0;
    rstn = 1'b0;
    standby = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    num_errors = 0;
    n_compared = 0;
    cyc = 0;
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    t_fault();
    t_parity();
    t_full_idle();
    t_break();
    t_tx();
    stop_test();
  end
endmodule
